// ===== tb/vpiu_core_model.sv
`timescale 1ns/1ps
module vpiu_core_model (
   input  wire clock_i,
   input  wire valid_i,
   input  wire en_i,
   output reg  ack_o
);
   // Random stalls so both prompt and late takes occur
   initial ack_o = 1'b0;
   always @(negedge clock_i) ack_o <= valid_i && en_i && $urandom % 2;
endmodule

// ===== tb/vpiu_props.sv
`timescale 1ns/1ps
module vpiu_props #(parameter NUM_VEC = 63, VEC_W = 6, ADDR_W = 21) (
   input wire               clock_i,
   input wire               rst_n_i,
   input wire [NUM_VEC-1:0] irq_req_i,
   input wire [ADDR_W-1:0]  vector_table_base_i,
   input wire               chip_reset_req_i,
   input wire               watchdog_reset_source_i,
   input wire               core_ack_i,
   input wire               irq_valid_o,
   input wire [VEC_W-1:0]   irq_vec_o,
   input wire [1:0]         irq_level_o,
   input wire [ADDR_W-1:0]  fetch_addr_o,
   input wire               reset_fetch_o,
   input wire [NUM_VEC-1:0] pending_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_take; irq_valid_o && core_ack_i; endsequence
   a_fetch_addr: assert property (irq_valid_o |->
      fetch_addr_o == $past(vector_table_base_i) + {irq_vec_o, 1'b0}) else $error("fetch");
   a_chip_fetch: assert property ($past(chip_reset_req_i && rst_n_i) |->
      reset_fetch_o && !irq_valid_o && irq_vec_o == 0) else $error("chip");
   a_wdog_fetch: assert property ($past(watchdog_reset_source_i && rst_n_i) |->
      reset_fetch_o && !irq_valid_o && irq_vec_o == $past(!chip_reset_req_i)) else $error("wd");
   a_lvl3_fixed: assert property (
      irq_valid_o && irq_vec_o inside {[2:5]} |-> irq_level_o == 3) else $error("lvl3");
   a_swi_fixed: assert property (
      irq_valid_o && irq_vec_o inside {[11:13]} |-> irq_level_o == 13 - irq_vec_o) else $error("swi");
   a_pend_hold: assert property (!(irq_valid_o && core_ack_i) |=>
      ($past(pending_o) & ~pending_o) == 0) else $error("hold");
   a_req_pends: assert property (|(irq_req_i >> 2) |=>
      (($past(irq_req_i) & ~pending_o) >> 2) == 0) else $error("req");
   a_ack_clears: assert property (s_take ##0 !irq_req_i[irq_vec_o] |=>
      !pending_o[$past(irq_vec_o)]) else $error("ack");
endmodule
bind vpiu_top vpiu_props #(.NUM_VEC(NUM_VEC), .VEC_W(VEC_W), .ADDR_W(ADDR_W)) i_vpiu_props (.*);

// ===== tb/vpiu_top_tb.sv
`timescale 1ns/1ps
module vpiu_top_tb;
   reg          clock_i = 0, rst_n_i = 0, chip = 0, wd = 0, en = 0;
   reg  [62:0]  req = 0, s;
   reg  [125:0] lvl = 0;
   reg  [20:0]  base = 0;
   wire         ack, valid, rf;
   wire [5:0]   vec;
   wire [1:0]   lv;
   wire [20:0]  fa;
   wire [62:0]  pd;
   integer      n_fail = 0, check_count = 0, i, k, n, v, q[$];
   vpiu_top i_vpiu_top (.clock_i(clock_i), .rst_n_i(rst_n_i), .irq_req_i(req),
      .irq_level_i(lvl), .vector_table_base_i(base), .chip_reset_req_i(chip),
      .watchdog_reset_source_i(wd), .core_ack_i(ack), .irq_valid_o(valid), .irq_vec_o(vec),
      .irq_level_o(lv), .fetch_addr_o(fa), .reset_fetch_o(rf), .pending_o(pd));
   vpiu_core_model i_core (.clock_i(clock_i), .valid_i(valid), .en_i(en), .ack_o(ack));
   task chk(input [31:0] got, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
         end
      end
   endtask
   function [1:0] eff(input integer v, input [1:0] l);
      eff = v < 6 ? 3 : v == 11 ? 2 : v == 12 ? 1 : v == 13 ? 0 :
         v < 16 ? (l ? l : 1) : (l == 3 ? 2 : l);
   endfunction
   task serve;
      begin
         @(negedge clock_i) req = 0;
         en = 1;
         for (k = 0; k < 400 && q.size() > 0; k++) @(negedge clock_i);
         chk(q.size(), 0);
         chk(|pd, 1'b0);
         en = 0;
         repeat (4) @(negedge clock_i);
      end
   endtask
   task stop_test;
      begin
         if (n_fail == 0 && check_count > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   always @(posedge clock_i) if (valid && ack) begin
      v = q.pop_front();
      chk(vec, v);
      chk(vec >= 2, 1'b1);
      chk(lv, eff(v, lvl[2*v+:2]));
      chk(fa, 21'(base + {v[5:0], 1'b0}));
   end
   initial forever #2.5 clock_i = ~clock_i;
   initial begin
      #100000;
      n_fail = n_fail + 1;
      stop_test;
   end
   initial begin
      i = $urandom(32'h2b4f0dd3);
      repeat (3) @(negedge clock_i);
      rst_n_i = 1;
      for (n = 0; n < 40; n++) begin
         base = $urandom;
         lvl = {$urandom, $urandom, $urandom, $urandom};
         // Ignored reset bits and fixed-level bits other than vector 4 forced in every round
         s = {$urandom, $urandom} | 63'h382f;
         req = s;
         for (k = 3; k >= 0; k--) for (i = 2; i < 63; i++)
            if (s[i] && eff(i, lvl[2*i+:2]) == k) q.push_back(i);
         serve;
      end
      chip = 1;
      wd = 1;
      req = 63'h4;
      q.push_back(2);
      repeat (3) @(negedge clock_i);
      chk({rf, valid, vec, fa}, {2'b10, 6'h0, base});
      chip = 0;
      repeat (2) @(negedge clock_i);
      chk({rf, valid, vec, fa}, {2'b10, 6'h1, 21'(base + 21'h2)});
      wd = 0;
      serve;
      stop_test;
   end
endmodule

// ===== verilog/vpiu_consts.vh
`ifndef VPIU_CONSTS_VH
`define VPIU_CONSTS_VH
// Vector numbering and table layout
`define VPIU_NUM_VEC        63
`define VPIU_VEC_W          6
`define VPIU_ADDR_W         21
`define VPIU_TGT_W          19
`define VPIU_ENTRY_SHIFT    1
`define VPIU_VEC_CHIP_RST   6'h00
`define VPIU_VEC_WDOG_RST   6'h01
`define VPIU_VEC_FIX3_LO    6'h02
`define VPIU_VEC_FIX3_HI    6'h05
`define VPIU_VEC_STEP       6'h06
`define VPIU_VEC_DBG_LO     6'h07
`define VPIU_VEC_DBG_HI     6'h0a
`define VPIU_VEC_SWI2       6'h0b
`define VPIU_VEC_SWI1       6'h0c
`define VPIU_VEC_SWI0       6'h0d
`define VPIU_VEC_CORE_HI    6'h0f
// Priority levels
`define VPIU_LVL_W          2
`define VPIU_LVL_0          2'h0
`define VPIU_LVL_1          2'h1
`define VPIU_LVL_2          2'h2
`define VPIU_LVL_3          2'h3
// Reset values
`define VPIU_BASE_RST       21'h000000
`endif

// ===== verilog/vpiu_top.v
// What this block does
// [R1] Higher priority level always wins first
// [R2] Same level: smallest vector number wins
// [R3] Software sets each source level within range
// [R4] Fetch address is base plus entry offset
// [R5] Entry offset twice vector; 19-bit targets
// [R6] Chip reset entry 0, watchdog entry 1
// [R7] Software puts jumps in resets, calls elsewhere
// [R8] Vectors two to five fixed level three
// [R9] Software interrupts 2,1,0 fixed levels 2,1,0
// [R10] Requests stay pending until core takes vector
`timescale 1ns/1ps
`include "vpiu_consts.vh"

module vpiu_top #(
   parameter NUM_VEC = `VPIU_NUM_VEC,
   parameter VEC_W   = `VPIU_VEC_W,
   parameter ADDR_W  = `VPIU_ADDR_W
) (
   input  wire                      clock_i,
   input  wire                      rst_n_i,
   input  wire [NUM_VEC-1:0]        irq_req_i,
   input  wire [2*NUM_VEC-1:0]      irq_level_i,
   input  wire [ADDR_W-1:0]         vector_table_base_i,
   input  wire                      chip_reset_req_i,
   input  wire                      watchdog_reset_source_i,
   input  wire                      core_ack_i,
   output wire                      irq_valid_o,
   output reg  [VEC_W-1:0]          irq_vec_o,
   output reg  [1:0]                irq_level_o,
   output reg  [ADDR_W-1:0]         fetch_addr_o,
   output reg                       reset_fetch_o,
   output wire [NUM_VEC-1:0]        pending_o
);

   // Per-level candidates, one bit per vector
   wire [NUM_VEC-1:0] lvl3_hit;
   wire [NUM_VEC-1:0] lvl2_hit;
   wire [NUM_VEC-1:0] lvl1_hit;
   wire [NUM_VEC-1:0] lvl0_hit;
   wire               taken;
   wire [ADDR_W-1:0]  win_off;
   wire [ADDR_W-1:0]  chip_off;
   wire [ADDR_W-1:0]  wdog_off;

   reg  [NUM_VEC-1:0] pend_q;
   reg  [NUM_VEC-1:0] pend_d;
   reg                valid_q;
   reg                valid_d;
   reg                rst_fetch_d;
   reg  [VEC_W-1:0]   vec_d;
   reg  [1:0]         lvl_d;
   reg  [ADDR_W-1:0]  addr_d;

   reg  [NUM_VEC-1:0] win_set;
   reg                win_found;
   reg  [VEC_W-1:0]   win_vec;
   reg  [1:0]         win_lvl;
   integer            j;
   genvar             g;

   // Range limits per vector; an illegal level is pulled to the nearest legal one
   generate
      for (g = 0; g < NUM_VEC; g = g + 1) begin : g_clamp
         wire [1:0] req_lvl;
         reg  [1:0] lim_lvl;

         assign req_lvl = irq_level_i[2*g +: 2];

         always @* begin
            if (g >= `VPIU_VEC_FIX3_LO && g <= `VPIU_VEC_FIX3_HI) begin
               lim_lvl = `VPIU_LVL_3; // [R8]
            end else if (g == `VPIU_VEC_SWI2) begin
               lim_lvl = `VPIU_LVL_2; // [R9]
            end else if (g == `VPIU_VEC_SWI1) begin
               lim_lvl = `VPIU_LVL_1; // [R9]
            end else if (g == `VPIU_VEC_SWI0) begin
               lim_lvl = `VPIU_LVL_0; // [R9]
            end else if (g <= `VPIU_VEC_CORE_HI) begin
               // Core, debug and supervision sources: levels 1 to 3 only
               lim_lvl = (req_lvl == `VPIU_LVL_0) ? `VPIU_LVL_1 : req_lvl; // [R3]
            end else begin
               // Peripheral sources never reach level 3
               lim_lvl = (req_lvl == `VPIU_LVL_3) ? `VPIU_LVL_2 : req_lvl; // [R3]
            end
         end

         // Vectors 0 and 1 never pend, so they never show up as candidates
         assign lvl3_hit[g] = pend_q[g] && (lim_lvl == `VPIU_LVL_3); // [R10]
         assign lvl2_hit[g] = pend_q[g] && (lim_lvl == `VPIU_LVL_2); // [R10]
         assign lvl1_hit[g] = pend_q[g] && (lim_lvl == `VPIU_LVL_1); // [R10]
         assign lvl0_hit[g] = pend_q[g] && (lim_lvl == `VPIU_LVL_0); // [R10]
      end
   endgenerate

   // Highest non-empty level wins outright
   always @* begin
      if (|lvl3_hit) begin
         win_set = lvl3_hit; // [R1]
         win_lvl = `VPIU_LVL_3;
      end else if (|lvl2_hit) begin
         win_set = lvl2_hit; // [R1]
         win_lvl = `VPIU_LVL_2;
      end else if (|lvl1_hit) begin
         win_set = lvl1_hit; // [R1]
         win_lvl = `VPIU_LVL_1;
      end else begin
         win_set = lvl0_hit; // [R1]
         win_lvl = `VPIU_LVL_0;
      end
   end

   // Scanning downwards lets the smallest vector of the level land last
   always @* begin
      win_found = |win_set;
      win_vec   = {VEC_W{1'b0}};
      for (j = NUM_VEC - 1; j >= 0; j = j - 1) begin
         if (win_set[j]) begin
            win_vec = j[VEC_W-1:0]; // [R2]
         end
      end
   end

   // An ack only counts while a winner is on show
   assign taken = core_ack_i && valid_q;

   // Two words per entry; the 19-bit call target lives in the entry itself
   assign win_off  = {{(ADDR_W-VEC_W){1'b0}}, win_vec}
                     << `VPIU_ENTRY_SHIFT; // [R5]
   assign chip_off = {{(ADDR_W-VEC_W){1'b0}}, `VPIU_VEC_CHIP_RST}
                     << `VPIU_ENTRY_SHIFT; // [R6]
   assign wdog_off = {{(ADDR_W-VEC_W){1'b0}}, `VPIU_VEC_WDOG_RST}
                     << `VPIU_ENTRY_SHIFT; // [R6]

   always @* begin
      pend_d    = pend_q | irq_req_i; // [R10]
      pend_d[0] = 1'b0;
      pend_d[1] = 1'b0;
      if (taken) begin
         // A fresh request in the ack cycle keeps its bit: set wins
         pend_d[irq_vec_o] = irq_req_i[irq_vec_o]; // [R10]
      end
   end

   // Reset fetch outranks every interrupt and hides it while held
   always @* begin
      if (chip_reset_req_i || watchdog_reset_source_i) begin
         valid_d = 1'b0;
      end else begin
         // Drop the winner for a cycle after its ack so it is not offered twice
         valid_d = win_found
                   && !(taken && win_vec == irq_vec_o && !irq_req_i[win_vec]);
      end
   end

   always @* begin
      rst_fetch_d = chip_reset_req_i || watchdog_reset_source_i; // [R6]
   end

   always @* begin
      if (chip_reset_req_i) begin
         vec_d  = `VPIU_VEC_CHIP_RST; // [R6]
         lvl_d  = `VPIU_LVL_3;
         addr_d = vector_table_base_i + chip_off; // [R6]
      end else if (watchdog_reset_source_i) begin
         vec_d  = `VPIU_VEC_WDOG_RST; // [R6]
         lvl_d  = `VPIU_LVL_3;
         addr_d = vector_table_base_i + wdog_off; // [R6]
      end else begin
         vec_d  = win_vec;
         lvl_d  = win_lvl;
         addr_d = vector_table_base_i + win_off; // [R4]
      end
   end

   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         pend_q <= {NUM_VEC{1'b0}};
      end else begin
         pend_q <= pend_d; // [R10]
      end
   end

   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         valid_q       <= 1'b0;
         reset_fetch_o <= 1'b0;
         irq_vec_o     <= {VEC_W{1'b0}};
         irq_level_o   <= `VPIU_LVL_0;
         fetch_addr_o  <= `VPIU_BASE_RST;
      end else begin
         valid_q       <= valid_d;
         reset_fetch_o <= rst_fetch_d;
         irq_vec_o     <= vec_d;
         irq_level_o   <= lvl_d;
         fetch_addr_o  <= addr_d;
      end
   end

   // Outputs come straight from flip-flops
   assign irq_valid_o = valid_q;
   assign pending_o   = pend_q;

endmodule
